// *** dcc_pkg.sv ***
// Package for the DAC code and calibration register bank
package dcc_pkg;
    localparam logic [15:0] DCC_OFS_CODE = 16'h2048;
    localparam logic [15:0] DCC_OFS_LOCK = 16'h2230;
    localparam logic [15:0] DCC_OFS_GAIN = 16'h2260;
    localparam logic [15:0] DCC_OFS_OFF_ON_LP = 16'h2264;
    localparam logic [15:0] DCC_OFS_OFF_OFF_LP = 16'h2268;
    localparam logic [15:0] DCC_OFS_OFF_ON_HS = 16'h22b8;
    localparam logic [15:0] DCC_OFS_OFF_OFF_HS = 16'h22bc;
    localparam logic [15:0] DCC_OFS_CONFIG = 16'h2010;
    localparam logic [11:0] DCC_RST_CODE = 12'h800;
    localparam logic [11:0] DCC_RST_GAIN = 12'h800;
    localparam logic [11:0] DCC_RST_OFFSET = 12'h000;
    localparam logic [31:0] DCC_RST_LOCK = 32'hde87a5a0;
    localparam logic [31:0] DCC_UNLOCK_KEY = 32'hde87a5af;
    localparam int DCC_GAIN_SEL_BIT = 12;
    localparam int DCC_ATTEN_BIT = 0;
    localparam int DCC_HIPOWER_BIT = 16;
    localparam logic [1:0] DCC_RESP_OKAY = 2'b00;
    localparam logic [1:0] DCC_RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [11:0] code;
        logic [31:0] lock;
        logic [11:0] gain;
        logic [11:0] off_on_lp;
        logic [11:0] off_off_lp;
        logic [11:0] off_on_hs;
        logic [11:0] off_off_hs;
        logic gain_sel;
        logic atten_en;
        logic hi_power;
        logic [15:0] aw_addr;
        logic aw_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic w_full;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [11:0] dac_code;
        logic [11:0] gain_trim;
        logic [11:0] offset_trim;
    } dcc_state_s;
endpackage : dcc_pkg

// *** dcc_regs.sv ***
// AXI4-Lite register bank for DAC code, gain trim and offset trims
`timescale 1ns/1ps
`default_nettype none
module dcc_regs
    import dcc_pkg::*;
#(
    parameter int CODE_W = 12
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [15:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [15:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [CODE_W-1:0] dac_code_o,
    output logic [CODE_W-1:0] gain_trim_o,
    output logic [CODE_W-1:0] offset_trim_o,
    output logic excitation_gain_select_o,
    output logic attenuator_enable_o,
    output logic high_power_o
);
    dcc_state_s st;
    dcc_state_s next_st;
    logic unlocked;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [31:0] rd;
    logic rd_hit;
    logic wr_go;

    // Trim fields are fixed at twelve bits in the shared state record
    if (CODE_W != 12) begin : g_code_w_check
        $error("dcc_regs serves only CODE_W of 12");
    end

    // Registered ports keep every output straight from a flip-flop
    assign s_axi_awready_o = st.awready;
    assign s_axi_wready_o = st.wready;

    function automatic logic [11:0] merge12(input logic [11:0] old,
            input logic [31:0] val, input logic [31:0] m);
        merge12 = (old & ~m[11:0]) | (val[11:0] & m[11:0]);
    endfunction : merge12

    always_comb begin
        unlocked = (st.lock == DCC_UNLOCK_KEY);
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{st.w_strb[i]}};
        end
        wval = st.w_data;
        wr_go = st.aw_full && st.w_full && !st.bvalid;
        rd_hit = 1'b1;
        case (s_axi_araddr_i & 16'hfffc)
            DCC_OFS_CODE: rd = {20'h0, st.code};
            DCC_OFS_LOCK: rd = st.lock;
            DCC_OFS_GAIN: rd = {20'h0, st.gain};
            DCC_OFS_OFF_ON_LP: rd = {20'h0, st.off_on_lp};
            DCC_OFS_OFF_OFF_LP: rd = {20'h0, st.off_off_lp};
            DCC_OFS_OFF_ON_HS: rd = {20'h0, st.off_on_hs};
            DCC_OFS_OFF_OFF_HS: rd = {20'h0, st.off_off_hs};
            DCC_OFS_CONFIG: rd = {15'h0, st.hi_power, 3'h0, st.gain_sel,
                                  11'h0, st.atten_en};
            default: begin
                rd = 32'h0;
                rd_hit = 1'b0;
            end
        endcase

        next_st = st;
        if (s_axi_awvalid_i && !st.aw_full) begin
            next_st.aw_addr = s_axi_awaddr_i & 16'hfffc;
            next_st.aw_full = 1'b1;
        end
        if (s_axi_wvalid_i && !st.w_full) begin
            next_st.w_data = s_axi_wdata_i;
            next_st.w_strb = s_axi_wstrb_i;
            next_st.w_full = 1'b1;
        end
        if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid = 1'b0;
        end
        if (wr_go) begin
            next_st.aw_full = 1'b0;
            next_st.w_full = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = DCC_RESP_OKAY;
            case (st.aw_addr)
                DCC_OFS_CODE: next_st.code = merge12(st.code, wval, wmask);
                DCC_OFS_LOCK: next_st.lock = (st.lock & ~wmask) |
                                             (wval & wmask);
                DCC_OFS_GAIN: if (unlocked)
                    next_st.gain = merge12(st.gain, wval, wmask);
                DCC_OFS_OFF_ON_LP: if (unlocked)
                    next_st.off_on_lp = merge12(st.off_on_lp, wval, wmask);
                DCC_OFS_OFF_OFF_LP: if (unlocked)
                    next_st.off_off_lp = merge12(st.off_off_lp, wval, wmask);
                DCC_OFS_OFF_ON_HS: if (unlocked)
                    next_st.off_on_hs = merge12(st.off_on_hs, wval, wmask);
                DCC_OFS_OFF_OFF_HS: if (unlocked)
                    next_st.off_off_hs = merge12(st.off_off_hs, wval, wmask);
                DCC_OFS_CONFIG: begin
                    if (st.w_strb[0]) next_st.atten_en = wval[DCC_ATTEN_BIT];
                    if (st.w_strb[1])
                        next_st.gain_sel = wval[DCC_GAIN_SEL_BIT];
                    if (st.w_strb[2])
                        next_st.hi_power = wval[DCC_HIPOWER_BIT];
                end
                default: next_st.bresp = DCC_RESP_SLVERR;
            endcase
        end
        next_st.arready = 1'b0;
        if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && !st.rvalid && !st.arready) begin
            next_st.arready = 1'b1;
            next_st.rvalid = 1'b1;
            next_st.rdata = rd;
            next_st.rresp = rd_hit ? DCC_RESP_OKAY : DCC_RESP_SLVERR;
        end
        next_st.dac_code = st.code;
        next_st.gain_trim = st.gain;
        if (st.hi_power) begin
            next_st.offset_trim = st.atten_en ? st.off_on_hs : st.off_off_hs;
        end else begin
            next_st.offset_trim = st.atten_en ? st.off_on_lp : st.off_off_lp;
        end
        // Ready kept as its own flop so the bus never sees a gate
        next_st.awready = ~next_st.aw_full;
        next_st.wready = ~next_st.w_full;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.code <= DCC_RST_CODE;
            st.dac_code <= DCC_RST_CODE;
            st.lock <= DCC_RST_LOCK;
            st.gain <= DCC_RST_GAIN;
            st.gain_trim <= DCC_RST_GAIN;
            st.off_on_lp <= DCC_RST_OFFSET;
            st.off_off_lp <= DCC_RST_OFFSET;
            st.off_on_hs <= DCC_RST_OFFSET;
            st.off_off_hs <= DCC_RST_OFFSET;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_bvalid_o = st.bvalid;
    assign s_axi_bresp_o = st.bresp;
    assign s_axi_arready_o = st.arready;
    assign s_axi_rvalid_o = st.rvalid;
    assign s_axi_rdata_o = st.rdata;
    assign s_axi_rresp_o = st.rresp;
    assign dac_code_o = st.dac_code;
    assign gain_trim_o = st.gain_trim;
    assign offset_trim_o = st.offset_trim;
    assign excitation_gain_select_o = st.gain_sel;
    assign attenuator_enable_o = st.atten_en;
    assign high_power_o = st.hi_power;

    // Helper: last write was a locked trim write
    logic locked_trim_wr;
    assign locked_trim_wr = wr_go && !unlocked &&
        (st.aw_addr == DCC_OFS_GAIN || st.aw_addr == DCC_OFS_OFF_ON_LP ||
         st.aw_addr == DCC_OFS_OFF_OFF_LP || st.aw_addr == DCC_OFS_OFF_ON_HS ||
         st.aw_addr == DCC_OFS_OFF_OFF_HS);

    a_locked_gain_kept: assert property (
        @(posedge clk_i) disable iff (reset_i)
        locked_trim_wr |=> $stable(st.gain) && $stable(st.off_on_lp)
            && $stable(st.off_off_lp) && $stable(st.off_on_hs)
            && $stable(st.off_off_hs))
        else $error("Trim changed while locked");
    a_gain_needs_key: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !$stable(st.gain) |-> $past(st.lock) == DCC_UNLOCK_KEY)
        else $error("Gain changed without key");
    a_code_to_dac: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ##1 dac_code_o == $past(st.code))
        else $error("DAC code does not follow register");
    a_offset_select: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ##1 offset_trim_o == ($past(st.hi_power) ?
            ($past(st.atten_en) ? $past(st.off_on_hs) : $past(st.off_off_hs))
          : ($past(st.atten_en) ? $past(st.off_on_lp) : $past(st.off_off_lp))))
        else $error("Wrong offset pair applied");
    a_read_upper_zero: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $rose(s_axi_rvalid_o) && $past(s_axi_araddr_i & 16'hfffc)
            != DCC_OFS_LOCK && $past(s_axi_araddr_i & 16'hfffc)
            != DCC_OFS_CONFIG |-> s_axi_rdata_o[31:12] == 20'h0)
        else $error("Upper read bits not zero");
    a_read_answer: assert property (
        @(posedge clk_i) disable iff (reset_i)
        s_axi_arvalid_i && !s_axi_rvalid_o && !s_axi_arready_o
            |=> s_axi_rvalid_o)
        else $error("Read not answered in one cycle");
    // Write steps: both halves held, then the response with ready back
    sequence s_write_held;
        !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
    endsequence
    sequence s_resp_up;
        s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o;
    endsequence
    a_write_resp: assert property (
        @(posedge clk_i) disable iff (reset_i)
        s_write_held |=> s_resp_up)
        else $error("Write not answered");
    a_gain_hold: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ##1 gain_trim_o == $past(st.gain))
        else $error("Gain trim output stale");
    // Offsets may only move after a write made under the key
    a_offset_needs_key: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !$stable({st.off_on_lp, st.off_off_lp, st.off_on_hs, st.off_off_hs})
            |-> $past(st.lock) == DCC_UNLOCK_KEY)
        else $error("Offset trim changed without key");
    // Full-word lock write stores the value as given, key or not
    a_lock_stored: assert property (
        @(posedge clk_i) disable iff (reset_i)
        wr_go && st.aw_addr == DCC_OFS_LOCK && st.w_strb == 4'hf
            |=> st.lock == $past(st.w_data))
        else $error("Lock write not stored");
    a_code_stored: assert property (
        @(posedge clk_i) disable iff (reset_i)
        wr_go && st.aw_addr == DCC_OFS_CODE && st.w_strb[1:0] == 2'b11
            |=> st.code == $past(st.w_data[11:0]))
        else $error("Code write not stored");
    a_gain_stored: assert property (
        @(posedge clk_i) disable iff (reset_i)
        wr_go && unlocked && st.aw_addr == DCC_OFS_GAIN
            && st.w_strb[1:0] == 2'b11
            |=> st.gain == $past(st.w_data[11:0]))
        else $error("Unlocked gain write not stored");
    a_config_stored: assert property (
        @(posedge clk_i) disable iff (reset_i)
        wr_go && st.aw_addr == DCC_OFS_CONFIG && st.w_strb == 4'hf
            |=> attenuator_enable_o == $past(st.w_data[DCC_ATTEN_BIT])
            && excitation_gain_select_o == $past(st.w_data[DCC_GAIN_SEL_BIT])
            && high_power_o == $past(st.w_data[DCC_HIPOWER_BIT]))
        else $error("Config bits not stored");
    // Every reset edge must leave the printed defaults behind
    a_reset_defaults: assert property (
        @(posedge clk_i)
        reset_i |=> st.lock == DCC_RST_LOCK && st.code == DCC_RST_CODE
            && st.gain == DCC_RST_GAIN && st.off_on_lp == DCC_RST_OFFSET
            && st.off_off_lp == DCC_RST_OFFSET
            && st.off_on_hs == DCC_RST_OFFSET
            && st.off_off_hs == DCC_RST_OFFSET)
        else $error("Defaults not restored by reset");
    // Holes in the map answer an error and read as zero
    a_read_hole: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $rose(s_axi_rvalid_o) && s_axi_rresp_o == DCC_RESP_SLVERR
            |-> s_axi_rdata_o == 32'h0)
        else $error("Unmapped read not zero");
endmodule : dcc_regs
`default_nettype wire

// *** dcc_regs_tb_top.sv ***
// Self-checking testbench for the DAC code and calibration register bank
`timescale 1ns/1ps
`default_nettype none
module dcc_regs_tb_top;
    import dcc_pkg::*;
    localparam logic [15:0] RA [7] = '{DCC_OFS_CODE, DCC_OFS_LOCK,
        DCC_OFS_GAIN, DCC_OFS_OFF_ON_LP, DCC_OFS_OFF_OFF_LP,
        DCC_OFS_OFF_ON_HS, DCC_OFS_OFF_OFF_HS};
    // Trim values in the same order as the four offset registers
    localparam logic [11:0] TV [4] = '{12'h7ff, 12'h001, 12'hfff, 12'h800};
    localparam logic [1:0] OK = DCC_RESP_OKAY;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [15:0] awaddr = '0;
    logic [15:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, gsel, att, hip;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, cfg;
    logic [11:0] code, gain, offs, exp_off;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    dcc_regs u_dcc_regs (.clk_i(clk_i), .reset_i(reset_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .dac_code_o(code), .gain_trim_o(gain),
        .offset_trim_o(offs), .excitation_gain_select_o(gsel),
        .attenuator_enable_o(att), .high_power_o(hip));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic close_out;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // Generous ceiling; a stuck handshake lands here
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Address and data offered together, each released when taken
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        check($sformatf("bresp %h", a), {30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [31:0] ed,
            input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        check($sformatf("rdata %h", a), rdata, ed);
        check($sformatf("rresp %h", a), {30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        @(posedge clk_i);
    endtask : rd

    // Outputs trail the registers by one cycle, so let two edges pass
    task automatic outs(input logic [11:0] ec, input logic [11:0] eg,
            input logic [11:0] eo);
        repeat (2) @(posedge clk_i);
        #1;
        check("dac_code_o", {20'h0, code}, {20'h0, ec});
        check("gain_trim_o", {20'h0, gain}, {20'h0, eg});
        check("offset_trim_o", {20'h0, offs}, {20'h0, eo});
        @(posedge clk_i);
    endtask : outs

    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rd(DCC_OFS_CODE, 32'h800, OK);
        rd(DCC_OFS_LOCK, DCC_RST_LOCK, OK);
        rd(DCC_OFS_GAIN, 32'h800, OK);
        for (int i = 3; i < 7; i++) rd(RA[i], 32'h0, OK);
        outs(12'h800, 12'h800, 12'h000);
        wr(DCC_OFS_CODE, 32'hffff_f200, 4'hf, OK);
        rd(DCC_OFS_CODE, 32'h200, OK);
        outs(12'h200, 12'h800, 12'h000);
        wr(DCC_OFS_CODE, 32'h0000_0e00, 4'hf, OK);
        rd(DCC_OFS_CODE, 32'he00, OK);
        // Key with its low byte missing leaves the bank locked
        wr(DCC_OFS_LOCK, DCC_UNLOCK_KEY, 4'he, OK);
        rd(DCC_OFS_LOCK, DCC_RST_LOCK, OK);
        for (int i = 2; i < 7; i++) wr(RA[i], 32'h0000_0555, 4'hf, OK);
        rd(DCC_OFS_GAIN, 32'h800, OK);
        for (int i = 3; i < 7; i++) rd(RA[i], 32'h0, OK);
        wr(DCC_OFS_LOCK, DCC_UNLOCK_KEY, 4'hf, OK);
        rd(DCC_OFS_LOCK, DCC_UNLOCK_KEY, OK);
        wr(DCC_OFS_GAIN, 32'hffff_ffff, 4'hf, OK);
        for (int i = 0; i < 4; i++) wr(RA[i+3], {20'hfffff, TV[i]}, 4'hf, OK);
        rd(DCC_OFS_GAIN, 32'hfff, OK);
        for (int i = 0; i < 4; i++) rd(RA[i+3], {20'h0, TV[i]}, OK);
        // Every attenuator, gain and power combination
        for (int m = 0; m < 8; m++) begin
            cfg = {15'h0, m[2], 3'h0, m[1], 11'h0, m[0]};
            exp_off = TV[{m[2], ~m[0]}];
            wr(DCC_OFS_CONFIG, cfg, 4'hf, OK);
            outs(12'he00, 12'hfff, exp_off);
            check("config", {29'h0, gsel, att, hip},
                {29'h0, m[1], m[0], m[2]});
        end
        // Any other lock value shuts the trims again
        wr(DCC_OFS_LOCK, 32'h1234_5678, 4'hf, OK);
        rd(DCC_OFS_LOCK, 32'h1234_5678, OK);
        wr(DCC_OFS_OFF_ON_LP, 32'h0, 4'hf, OK);
        rd(DCC_OFS_OFF_ON_LP, {20'h0, TV[0]}, OK);
        // Hole in the map answers with an error and reads zero
        wr(16'h2004, 32'h1, 4'hf, DCC_RESP_SLVERR);
        rd(16'h2004, 32'h0, DCC_RESP_SLVERR);
        // Reset in mid-run restores defaults over written values
        reset_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        rd(DCC_OFS_LOCK, DCC_RST_LOCK, OK);
        for (int i = 3; i < 7; i++) rd(RA[i], 32'h0, OK);
        outs(12'h800, 12'h800, 12'h000);
        check("config", {29'h0, gsel, att, hip}, 32'h0);
        close_out();
    end
endmodule : dcc_regs_tb_top
`default_nettype wire
